/* File: dpsem_pkg.sv */
// package: constants and types for the semaphore-port host controller
package dpsem_pkg;
  // ==========================================================================
  // flag space geometry
  localparam int unsigned FLAG_COUNT = 8;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned DATA_W     = 9;
  // ==========================================================================
  // pin timing, counted in i_mclk cycles
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETUP_NS      = 20;
  localparam int unsigned SETUP_CYC     =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_NS    = 10;
  localparam int unsigned RECOVER_CYC   =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  // read path waits out both synchroniser stages before sampling
  localparam logic [3:0]  SYNC_CYC      = 4'h2;
  // ==========================================================================
  // host commands
  typedef enum logic [1:0] {
    DPSEM_CMD_CLAIM,
    DPSEM_CMD_RELEASE,
    DPSEM_CMD_POLL,
    DPSEM_CMD_INIT
  } dpsem_cmd_t;
endpackage : dpsem_pkg

/* File: dpsem_sync.sv */
// two-flop synchroniser for the data pins read back from the device
`timescale 1ns/100ps
`default_nettype none
module dpsem_sync (
  input  wire logic                       i_mclk,
  input  wire logic                       i_arst_n,
  input  wire logic [dpsem_pkg::DATA_W-1:0] i_async,
  output logic      [dpsem_pkg::DATA_W-1:0] o_sync
);
  import dpsem_pkg::*;
  // ==========================================================================
  // first stage is only read by the second
  logic [DATA_W-1:0] meta_q;
  logic [DATA_W-1:0] sync_q;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule : dpsem_sync
`default_nettype wire

/* File: dpsem_host.sv */
// host controller driving one port of a dual-port semaphore flag space
`timescale 1ns/100ps
`default_nettype none
module dpsem_host (
  input  wire logic                         i_mclk,
  input  wire logic                         i_arst_n,
  input  wire logic                         i_req_valid,
  input  wire dpsem_pkg::dpsem_cmd_t        i_req_cmd,
  input  wire logic [dpsem_pkg::IDX_W-1:0]  i_req_index,
  input  wire logic                         i_retry_until_won,
  output logic                              o_req_ready,
  output logic                              o_done,
  output logic                              o_granted,
  output logic                              o_flag_level,
  input  wire logic [dpsem_pkg::DATA_W-1:0] i_data_in,
  output logic      [dpsem_pkg::DATA_W-1:0] o_data_out,
  output logic      [dpsem_pkg::DATA_W-1:0] o_data_oe,
  output logic [dpsem_pkg::IDX_W-1:0]       o_flag_index_lines,
  output logic                              o_flag_space_select_n,
  output logic                              o_chip_enable_n,
  output logic                              o_write_n,
  output logic                              o_output_enable_n
);
  import dpsem_pkg::*;

  // ==========================================================================
  // states and registers
  typedef enum logic [2:0] {
    ST_IDLE, ST_WRITE, ST_GAP, ST_READ, ST_SAMPLE, ST_DONE
  } dpsem_state_t;

  dpsem_state_t      state_q, state_d;
  dpsem_cmd_t        cmd_q, cmd_d;
  logic [IDX_W-1:0]  idx_q, idx_d;
  logic              retry_q, retry_d;
  logic              wbit_q, wbit_d;
  logic [3:0]        cnt_q, cnt_d;
  logic              ready_q, ready_d;
  logic              done_q, done_d;
  logic              granted_q, granted_d;
  logic              level_q, level_d;
  logic              sel_q, sel_d;
  logic              wr_q, wr_d;
  logic              rd_q, rd_d;
  logic [DATA_W-1:0] rdata;

  dpsem_sync u_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_async  (i_data_in),
    .o_sync   (rdata)
  );

  // flag read: any low bit is taken as zero since the device replicates it
  function automatic logic flag_of(input logic [DATA_W-1:0] d);
    return &d;
  endfunction : flag_of

  // ==========================================================================
  // next-state logic for the access sequencer
  always_comb begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    idx_d     = idx_q;
    retry_d   = retry_q;
    wbit_d    = wbit_q;
    cnt_d     = cnt_q;
    ready_d   = 1'b0;
    done_d    = 1'b0;
    granted_d = granted_q;
    level_d   = level_q;
    sel_d     = 1'b0;
    wr_d      = 1'b0;
    rd_d      = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        ready_d = 1'b1;
        if (i_req_valid && ready_q) begin
          ready_d = 1'b0;
          cmd_d   = i_req_cmd;
          retry_d = i_retry_until_won;
          // init sweeps every flag from index zero
          idx_d   = (i_req_cmd == DPSEM_CMD_INIT) ? '0 : i_req_index;
          // claim writes zero first, never read-then-write
          wbit_d  = (i_req_cmd == DPSEM_CMD_CLAIM) ? 1'b0 : 1'b1;
          cnt_d   = 4'(SETUP_CYC);
          state_d = (i_req_cmd == DPSEM_CMD_POLL) ? ST_READ : ST_WRITE;
        end
      end
      ST_WRITE: begin
        // select low, write strobe; chip enable stays high
        sel_d = 1'b1;
        wr_d  = 1'b1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == CNT_ZERO) begin
          sel_d   = 1'b0;
          wr_d    = 1'b0;
          cnt_d   = 4'(RECOVER_CYC);
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        // select released between cycles so the read latch refreshes
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == CNT_ZERO) begin
          cnt_d = 4'(SETUP_CYC);
          if (cmd_q == DPSEM_CMD_INIT && idx_q != IDX_W'(FLAG_COUNT - 1)) begin
            idx_d   = idx_q + IDX_W'(1);
            state_d = ST_WRITE;
          end else if (cmd_q == DPSEM_CMD_CLAIM && !wbit_q) begin
            state_d = ST_READ;
          end else if (cmd_q == DPSEM_CMD_CLAIM) begin
            state_d = ST_DONE; // withdrawn after a failed claim
          end else if (cmd_q == DPSEM_CMD_POLL) begin
            state_d = ST_READ;
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_READ: begin
        sel_d = 1'b1;
        rd_d  = 1'b1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == CNT_ZERO) begin
          rd_d    = 1'b1;
          cnt_d   = SYNC_CYC; // two synchroniser stages
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        sel_d = 1'b1;
        rd_d  = 1'b1;
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == CNT_ZERO) begin
          sel_d   = 1'b0;
          rd_d    = 1'b0;
          level_d = flag_of(rdata);
          // zero read on our side means we own it
          granted_d = !flag_of(rdata);
          cnt_d     = 4'(RECOVER_CYC);
          if (flag_of(rdata) && cmd_q == DPSEM_CMD_CLAIM && !retry_q) begin
            // failed: withdraw the stale request
            wbit_d  = 1'b1;
            cnt_d   = 4'(SETUP_CYC);
            state_d = ST_WRITE;
          end else if (flag_of(rdata) && cmd_q == DPSEM_CMD_CLAIM) begin
            // stay a claim with the zero still pending, so every gap loops
            // back to another read until the far side lets the flag go
            state_d = ST_GAP; // keep reading
          end else begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        done_d  = 1'b1;
        if (cmd_q == DPSEM_CMD_RELEASE || cmd_q == DPSEM_CMD_INIT) begin
          granted_d = 1'b0;
          level_d   = 1'b1;
        end
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers; pins idle deasserted after reset
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q   <= ST_IDLE;
      cmd_q     <= DPSEM_CMD_POLL;
      idx_q     <= '0;
      retry_q   <= 1'b0;
      wbit_q    <= 1'b1;
      cnt_q     <= CNT_ZERO;
      ready_q   <= 1'b0;
      done_q    <= 1'b0;
      granted_q <= 1'b0;
      level_q   <= 1'b1;
      sel_q     <= 1'b0;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      idx_q     <= idx_d;
      retry_q   <= retry_d;
      wbit_q    <= wbit_d;
      cnt_q     <= cnt_d;
      ready_q   <= ready_d;
      done_q    <= done_d;
      granted_q <= granted_d;
      level_q   <= level_d;
      sel_q     <= sel_d;
      wr_q      <= wr_d;
      rd_q      <= rd_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from flops except the tied-high chip enable
  assign o_req_ready           = ready_q;
  assign o_done                = done_q;
  assign o_granted             = granted_q;
  assign o_flag_level          = level_q;
  // only bit zero matters to the device, the rest follow it
  assign o_data_out            = {DATA_W{wbit_q}};
  assign o_data_oe             = {DATA_W{wr_q}};
  assign o_flag_index_lines    = idx_q;
  assign o_flag_space_select_n = !sel_q;
  assign o_chip_enable_n       = 1'b1; // held high: flag access, not array
  assign o_write_n             = !wr_q;
  assign o_output_enable_n     = !rd_q;
endmodule : dpsem_host
`default_nettype wire

/* File: dpsem_host_asserts.sv */
// checker for the semaphore-port host controller pins
`timescale 1ns/100ps
`default_nettype none
module dpsem_host_asserts
  import dpsem_pkg::*;
(
  input wire logic                         i_mclk,
  input wire logic                         i_arst_n,
  input wire logic                         i_req_valid,
  input wire dpsem_pkg::dpsem_cmd_t        i_req_cmd,
  input wire logic                         o_req_ready,
  input wire logic                         o_done,
  input wire logic [dpsem_pkg::DATA_W-1:0] o_data_out,
  input wire logic [dpsem_pkg::DATA_W-1:0] o_data_oe,
  input wire logic                         o_chip_enable_n,
  input wire logic                         o_flag_space_select_n,
  input wire logic                         o_write_n,
  input wire logic                         o_output_enable_n
);
  // ==========================================================================
  // clocking and sequences
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // a claim must lead with its write cycle, never with a read
  sequence s_claim_taken;
    i_req_valid && o_req_ready && i_req_cmd == DPSEM_CMD_CLAIM;
  endsequence
  sequence s_write_first;
    1'b1 ##[1:3] !o_write_n;
  endsequence
  // ==========================================================================
  // pin relations
  a_write_held: assert property ($fell(o_write_n) |->
    !o_write_n [*2] ##1 o_write_n)
    else $error("write strobe not two cycles long");
  a_data_flat: assert property (!o_write_n |->
    (o_data_out == 9'h000 || o_data_out == 9'h1ff))
    else $error("written data bits differ");
  a_write_drive: assert property (!o_write_n |->
    (o_data_oe == 9'h1ff && !o_flag_space_select_n))
    else $error("write without select or data drive");
  a_read_clean: assert property (!o_output_enable_n |->
    (o_write_n && o_data_oe == 9'h000 && !o_flag_space_select_n))
    else $error("read cycle overlaps a write or drive");
  a_poll_gap: assert property ($fell(o_output_enable_n) |->
    $past(o_flag_space_select_n))
    else $error("read started without select released");
  a_claim_order: assert property (s_claim_taken |->
    o_output_enable_n throughout s_write_first)
    else $error("claim did not write before reading");
  a_idle_quiet: assert property (o_req_ready |->
    (o_flag_space_select_n && o_write_n && o_output_enable_n))
    else $error("pins active while idle");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  // the array enable must stay off while the flag space is selected
  a_array_off: assert property (!o_flag_space_select_n |->
    o_chip_enable_n)
    else $error("array enabled during flag access");
endmodule : dpsem_host_asserts
bind dpsem_host dpsem_host_asserts u_chk (.i_mclk(i_mclk),
  .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
  .o_req_ready(o_req_ready), .o_done(o_done), .o_data_out(o_data_out),
  .o_data_oe(o_data_oe), .o_flag_space_select_n(o_flag_space_select_n),
  .o_write_n(o_write_n), .o_output_enable_n(o_output_enable_n),
  .o_chip_enable_n(o_chip_enable_n));
`default_nettype wire

/* File: dpsem_dev_model.sv */
// behavioural model of the eight-flag semaphore space, both ports
`timescale 1ns/100ps
`default_nettype none
module dpsem_dev_model (
  input  wire logic       i_mclk,
  input  wire logic       i_sel_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_oe_n,
  input  wire logic [2:0] i_idx,
  input  wire logic [8:0] i_bus,
  output logic      [8:0] o_bus,
  input  wire logic       i_r_wr,
  input  wire logic [2:0] i_r_idx,
  input  wire logic       i_r_d
);
  // latches start dirty: no power-up clear, software must free them
  logic [7:0] l_req = 8'h5a;
  logic [7:0] r_req = 8'h3c;
  logic [7:0] lo    = 8'h00;
  logic [7:0] ro    = 8'h00;
  logic       cap   = 1'b1;
  logic       held  = 1'b0;
  logic [8:0] last  = 9'h000;
  // ==========================================================================
  // request latches, ownership and the read holding register
  always @(posedge i_mclk) begin
    if (!i_sel_n && !i_wr_n) l_req[i_idx] = i_bus[0];
    if (i_r_wr) r_req[i_r_idx] = i_r_d;
    for (int i = 0; i < 8; i++) begin
      if (lo[i] && l_req[i]) lo[i] = 1'b0;
      if (ro[i] && r_req[i]) ro[i] = 1'b0;
      // left wins a same-cycle tie: one grant only
      if (!lo[i] && !ro[i]) begin
        if (!l_req[i]) lo[i] = 1'b1;
        else if (!r_req[i]) ro[i] = 1'b1;
      end
    end
    // read pins change only after the edge, so the host never races them
    if (i_sel_n || i_oe_n) held <= 1'b0;
    else if (!held) begin
      held <= 1'b1;
      cap  <= ~lo[i_idx];
    end
    last <= o_bus;
  end
  // released pins toggle so a stale value is never mistaken for a read
  assign o_bus = held ? {9{cap}} : ~last;
endmodule : dpsem_dev_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench: host controller against the flag space model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dpsem_pkg::*;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, valid = 1'b0, retry = 1'b0;
  logic r_wr = 1'b0, r_d = 1'b1, ready, done, granted, level;
  logic sel_n, ce_n, wr_n, oe_n;
  logic [2:0] idx = 3'h0, r_idx = 3'h0, lines;
  logic [8:0] d_out, d_oe, m_bus, bus;
  dpsem_cmd_t cmd = DPSEM_CMD_POLL;
  int num_errors = 0, checked = 0, cycles = 0;
  // ==========================================================================
  // clock, wire resolution and instances
  always #5 i_mclk = ~i_mclk;
  assign bus = (d_oe & d_out) | (~d_oe & m_bus);
  dpsem_host DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req_valid(valid),
    .i_req_cmd(cmd), .i_req_index(idx), .i_retry_until_won(retry),
    .o_req_ready(ready), .o_done(done), .o_granted(granted),
    .o_flag_level(level), .i_data_in(bus), .o_data_out(d_out),
    .o_data_oe(d_oe), .o_flag_index_lines(lines),
    .o_flag_space_select_n(sel_n), .o_chip_enable_n(ce_n),
    .o_write_n(wr_n), .o_output_enable_n(oe_n));
  dpsem_dev_model u_dev (.i_mclk(i_mclk), .i_sel_n(sel_n), .i_wr_n(wr_n),
    .i_oe_n(oe_n), .i_idx(lines), .i_bus(bus), .o_bus(m_bus),
    .i_r_wr(r_wr), .i_r_idx(r_idx), .i_r_d(r_d));
  // ==========================================================================
  // shared tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one command: held until taken, then wait for its done pulse
  task automatic run(input dpsem_cmd_t c, input logic [2:0] ix,
                     input logic rt);
    @(posedge i_mclk) begin
      valid <= 1'b1;
      cmd   <= c;
      idx   <= ix;
      retry <= rt;
    end
    @(negedge i_mclk);
    while (ready !== 1'b1) @(negedge i_mclk);
    @(posedge i_mclk) valid <= 1'b0;
    @(negedge i_mclk);
    while (done !== 1'b1) @(negedge i_mclk);
  endtask : run
  // far-side processor writes one flag latch
  task automatic rwrite(input logic [2:0] ix, input logic v);
    @(posedge i_mclk) begin
      r_wr  <= 1'b1;
      r_idx <= ix;
      r_d   <= v;
    end
    @(posedge i_mclk) r_wr <= 1'b0;
    @(negedge i_mclk);
  endtask : rwrite
  // ==========================================================================
  // scenarios
  task automatic s_init;
    run(DPSEM_CMD_INIT, 3'h0, 1'b0);
    for (int k = 0; k < 8; k++) chk(u_dev.l_req[k], 1'b1);
    // far side frees its own latches too; then every flag must be free
    for (int k = 0; k < 8; k++) begin
      rwrite(3'(k), 1'b1);
      chk(u_dev.lo[k] | u_dev.ro[k], 1'b0);
    end
  endtask : s_init
  task automatic s_handover;
    run(DPSEM_CMD_CLAIM, 3'h2, 1'b0);
    chk({granted, level}, 2'b10);
    chk(u_dev.ro[2], 1'b0);
    rwrite(3'h2, 1'b0);
    chk(u_dev.lo[2] & ~u_dev.ro[2], 1'b1);
    run(DPSEM_CMD_RELEASE, 3'h2, 1'b0);
    chk(u_dev.ro[2], 1'b1);
    run(DPSEM_CMD_POLL, 3'h2, 1'b0);
    chk({granted, level}, 2'b01);
  endtask : s_handover
  task automatic s_withdraw;
    run(DPSEM_CMD_CLAIM, 3'h2, 1'b0);
    chk({granted, u_dev.l_req[2]}, 2'b01);
    rwrite(3'h2, 1'b1);
    chk(u_dev.lo[2] | u_dev.ro[2], 1'b0);
  endtask : s_withdraw
  // far side holds the flag for a while; the retrying claim must win
  task automatic s_retry;
    rwrite(3'h5, 1'b0);
    fork
      run(DPSEM_CMD_CLAIM, 3'h5, 1'b1);
      begin
        repeat (60) @(posedge i_mclk);
        rwrite(3'h5, 1'b1);
      end
    join
    chk({granted, u_dev.lo[5]}, 2'b11);
  endtask : s_retry
  // ==========================================================================
  // timeout and main sequence
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    s_init();
    s_handover();
    s_withdraw();
    s_retry();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
